// ---- core/timer_capture_compare_pwm.sv ----
`timescale 1ns/100ps
module timer_capture_compare_pwm
   import tccp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic enable_i,
   input wire logic [2:0] timer0_clock_select_i,
   input wire logic [1:0] timer1_clock_select_i,
   input wire logic cascade_select_i,
   input wire logic timer0_capture_enable_i,
   input wire logic timer1_capture_enable_i,
   input wire logic pwm_enable_bit_i,
   input wire logic pwm_polarity_i,
   input wire logic pwm_output_pin_select_i,
   input wire logic timer0_compare_select_i,
   input wire logic [7:0] compare_data0_i,
   input wire logic [7:0] compare_data1_i,
   input wire logic [7:0] pwm_period_low_i,
   input wire logic [7:0] pwm_duty_low_i,
   input wire logic [3:0] pwm_high_bits_reg_i,
   input wire logic [1:0] edge_select0_i,
   input wire logic [1:0] edge_select1_i,
   input wire logic capture_input0_i,
   input wire logic capture_input1_i,
   output logic [7:0] read_value0_o,
   output logic [7:0] read_value1_o,
   output logic timer0_irq_o,
   output logic timer1_irq_o,
   output logic ext_irq0_o,
   output logic ext_irq1_o,
   output logic timer0_compare_pin_o,
   output logic timer1_compare_pin_o
);
   logic [11:0] pre0, pre1, next_pre0, next_pre1;
   logic [7:0] count0, count1, next_count0, next_count1;
   logic [7:0] timer0_capture_enable, timer1_capture_enable, next_timer0_capture_enable, next_timer1_capture_enable;
   logic [9:0] pcount, next_pcount, duty_act, next_duty_act;
   logic in0_q, in1_q, next_in0_q, next_in1_q;
   logic tog0, tog1, next_tog0, next_tog1;
   logic pwm_out, next_pwm_out;
   logic t0irq, t1irq, e0irq, e1irq;
   logic tick0, tick1, match0, match1, edge0, edge1, pwm_mode, wide;
   logic [9:0] period, duty_hold;
   logic armed, next_armed;

   function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
      edge_hit = ((sel == EDGE_FALL || sel == EDGE_BOTH) && prev && !cur) ||
                 ((sel == EDGE_RISE || sel == EDGE_BOTH) && !prev && cur);
   endfunction : edge_hit

   function automatic logic wrap_hit(input logic [9:0] cnt, input logic [9:0] top);
      wrap_hit = (({1'b0, cnt} + 11'h001) >= {1'b0, top});
   endfunction : wrap_hit

   function automatic logic [11:0] t0_ratio(input logic [2:0] sel);
      case (sel)
         3'h0: t0_ratio = 12'(2) * T0_CYC_UNIT;
         3'h1: t0_ratio = 12'(4) * T0_CYC_UNIT;
         3'h2: t0_ratio = 12'(8) * T0_CYC_UNIT;
         3'h3: t0_ratio = 12'(32) * T0_CYC_UNIT;
         default: t0_ratio = 12'(128) * T0_CYC_UNIT;
      endcase
   endfunction : t0_ratio

   function automatic logic [11:0] t1_ratio(input logic [1:0] sel);
      case (sel)
         TIMER1_CLOCK_SELECT_DIV1: t1_ratio = SRC_CYC_00;
         TIMER1_CLOCK_SELECT_DIV2: t1_ratio = SRC_CYC_01;
         default: t1_ratio = SRC_CYC_10;
      endcase
   endfunction : t1_ratio

   assign wide = cascade_select_i && (timer1_clock_select_i == TIMER1_CLOCK_SELECT_CASCADE);
   assign pwm_mode = pwm_enable_bit_i && !wide;
   assign period = {pwm_high_bits_reg_i[3:2], pwm_period_low_i};
   assign duty_hold = {pwm_high_bits_reg_i[1:0], pwm_duty_low_i};
   assign tick0 = enable_i && (pre0 + 12'h001 >= t0_ratio(timer0_clock_select_i));
   assign tick1 = enable_i && (pre1 + 12'h001 >= t1_ratio(timer1_clock_select_i));
   // No edge on the first sample after reset
   assign edge0 = armed && edge_hit(edge_select0_i, in0_q, capture_input0_i);
   assign edge1 = armed && edge_hit(edge_select1_i, in1_q, capture_input1_i);
   assign match0 = wide ? ({count1, count0} == {compare_data1_i, compare_data0_i})
                        : (count0 == compare_data0_i);
   assign match1 = !wide && (count1 == compare_data1_i);

   always_comb begin
      next_pre0 = pre0;
      next_pre1 = pre1;
      next_count0 = count0;
      next_count1 = count1;
      next_timer0_capture_enable = timer0_capture_enable;
      next_timer1_capture_enable = timer1_capture_enable;
      next_tog0 = tog0;
      next_tog1 = tog1;
      next_in0_q = capture_input0_i;
      next_in1_q = capture_input1_i;
      next_armed = 1'b1;
      if (tick0) begin
         next_pre0 = PRESCALE_RESET;
      end else begin
         next_pre0 = pre0 + 12'h001;
      end
      if (tick1) begin
         next_pre1 = PRESCALE_RESET;
      end else begin
         next_pre1 = pre1 + 12'h001;
      end
      if (tick0) begin
         if (match0) begin
            next_count0 = COUNT_RESET;
            next_tog0 = !tog0;
            if (wide) begin
               next_count1 = COUNT_RESET;
            end
         end else begin
            next_count0 = count0 + 8'h01;
            if (wide && count0 == 8'hff) begin
               next_count1 = count1 + 8'h01;
            end
         end
      end
      if (!wide && !pwm_mode && tick1) begin
         if (match1) begin
            next_count1 = COUNT_RESET;
            next_tog1 = !tog1;
         end else begin
            next_count1 = count1 + 8'h01;
         end
      end
      if (enable_i && timer0_capture_enable_i && edge0) begin
         next_timer0_capture_enable = count0;
         next_count0 = COUNT_RESET;
         if (wide) begin
            next_timer1_capture_enable = count1;
            next_count1 = COUNT_RESET;
         end
      end
      if (enable_i && !wide && timer1_capture_enable_i && edge1) begin
         next_timer1_capture_enable = count1;
         next_count1 = COUNT_RESET;
      end
      if (!enable_i) begin
         next_pre0 = pre0;
         next_pre1 = pre1;
         next_in0_q = in0_q;
         next_in1_q = in1_q;
      end
   end

   always_comb begin
      next_pcount = pcount;
      next_duty_act = duty_act;
      next_pwm_out = pwm_out;
      if (pwm_mode && tick1) begin
         if (wrap_hit(pcount, period)) begin
            next_pcount = PWM_RESET;
            next_duty_act = duty_hold;
         end else begin
            next_pcount = pcount + 10'h001;
         end
      end
      if (duty_act == 10'h000) begin
         next_pwm_out = !pwm_polarity_i;
      end else if (duty_act >= period) begin
         next_pwm_out = pwm_polarity_i;
      end else begin
         next_pwm_out = (pcount < duty_act) ? pwm_polarity_i : !pwm_polarity_i;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre0 <= PRESCALE_RESET;
         pre1 <= PRESCALE_RESET;
         count0 <= COUNT_RESET;
         count1 <= COUNT_RESET;
         timer0_capture_enable <= COUNT_RESET;
         timer1_capture_enable <= COUNT_RESET;
         in0_q <= 1'b0;
         in1_q <= 1'b0;
         armed <= 1'b0;
         tog0 <= 1'b0;
         tog1 <= 1'b0;
         pcount <= PWM_RESET;
         duty_act <= PWM_RESET;
         pwm_out <= 1'b0;
         t0irq <= 1'b0;
         t1irq <= 1'b0;
         e0irq <= 1'b0;
         e1irq <= 1'b0;
         read_value0_o <= COUNT_RESET;
         read_value1_o <= COUNT_RESET;
         timer0_compare_pin_o <= 1'b0;
         timer1_compare_pin_o <= 1'b0;
      end else if (enable_i) begin
         pre0 <= next_pre0;
         pre1 <= next_pre1;
         count0 <= next_count0;
         count1 <= next_count1;
         timer0_capture_enable <= next_timer0_capture_enable;
         timer1_capture_enable <= next_timer1_capture_enable;
         in0_q <= next_in0_q;
         in1_q <= next_in1_q;
         armed <= next_armed;
         tog0 <= next_tog0;
         tog1 <= next_tog1;
         pcount <= next_pcount;
         duty_act <= next_duty_act;
         pwm_out <= next_pwm_out;
         t0irq <= tick0 && match0;
         t1irq <= tick1 && match1 && !pwm_mode;
         e0irq <= edge0;
         e1irq <= edge1;
         read_value0_o <= timer0_capture_enable_i ? next_timer0_capture_enable : next_count0;
         read_value1_o <= (timer1_capture_enable_i || (wide && timer0_capture_enable_i))
                          ? next_timer1_capture_enable : next_count1;
         timer0_compare_pin_o <= timer0_compare_select_i && next_tog0;
         if (pwm_output_pin_select_i && pwm_mode) begin
            timer1_compare_pin_o <= next_pwm_out;
         end else begin
            timer1_compare_pin_o <= pwm_output_pin_select_i && !pwm_enable_bit_i
                                    && (wide ? next_tog0 : next_tog1);
         end
      end
   end

   assign timer0_irq_o = t0irq;
   assign timer1_irq_o = t1irq;
   assign ext_irq0_o = e0irq;
   assign ext_irq1_o = e1irq;

   a_capture_clears: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && timer0_capture_enable_i && edge0 && !tick0 |=> count0 == COUNT_RESET)
      else $error("count not cleared on capture");
   a_capture_value: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && timer0_capture_enable_i && edge0 |=> timer0_capture_enable == $past(count0))
      else $error("capture value wrong");
   a_edge_irq: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && edge1 |=> ext_irq1_o)
      else $error("edge irq missing");
   a_pin_off_pwm: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && !pwm_output_pin_select_i |=> !timer1_compare_pin_o)
      else $error("t1 pin active while deselected");
   a_duty_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && pwm_mode && tick1 && wrap_hit(pcount, period) |=> duty_act == $past(duty_hold))
      else $error("duty not loaded at period");
   a_duty_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && duty_act == 10'h000 |=> pwm_out == !$past(pwm_polarity_i))
      else $error("zero duty level wrong");
   a_duty_full: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && duty_act != 10'h000 && duty_act >= period |=> pwm_out == $past(pwm_polarity_i))
      else $error("full duty level wrong");
   a_match_toggle: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && tick0 && match0 |=> tog0 != $past(tog0) ##0 timer0_irq_o)
      else $error("match did not toggle");

   // Steps of the timer 1 and PWM behaviours
   sequence s_capture1;
      enable_i && !wide && timer1_capture_enable_i && edge1;
   endsequence
   sequence s_match1;
      enable_i && !wide && !pwm_mode && tick1 && match1;
   endsequence
   sequence s_wrap;
      enable_i && pwm_mode && tick1 && wrap_hit(pcount, period);
   endsequence

   a_t1_capture_value: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_capture1 |=> timer1_capture_enable == $past(count1) && count1 == COUNT_RESET)
      else $error("timer 1 capture wrong");
   a_t1_capture_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_capture1 |=> read_value1_o == timer1_capture_enable)
      else $error("timer 1 read not capture");
   a_t1_toggle: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_match1 |=> tog1 != $past(tog1) ##0 timer1_irq_o)
      else $error("timer 1 match did not toggle");
   a_pwm_wrap: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_wrap |=> pcount == PWM_RESET)
      else $error("pwm count did not restart");
   a_edge0_irq: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && edge0 |=> ext_irq0_o)
      else $error("edge 0 irq missing");
   a_read_capture: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && timer0_capture_enable_i |=> read_value0_o == timer0_capture_enable)
      else $error("timer 0 read not capture");
endmodule : timer_capture_compare_pwm

// ---- core/tccp_pkg.sv ----
package tccp_pkg;
   // Clock select codes of timer 1
   localparam logic [1:0] TIMER1_CLOCK_SELECT_DIV1 = 2'h0;
   localparam logic [1:0] TIMER1_CLOCK_SELECT_DIV2 = 2'h1;
   localparam logic [1:0] TIMER1_CLOCK_SELECT_DIV8 = 2'h2;
   localparam logic [1:0] TIMER1_CLOCK_SELECT_CASCADE = 2'h3;
   // Source clock periods (ns) at a 4 MHz oscillator
   localparam int OSC_PERIOD_NS = 250;
   localparam int SRC_PERIOD_00_NS = 250;
   localparam int SRC_PERIOD_01_NS = 500;
   localparam int SRC_PERIOD_10_NS = 2000;
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int OSC_CYCLES = (OSC_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [11:0] SRC_CYC_00 = 12'((SRC_PERIOD_00_NS + CLOCK_PERIOD_NS - 1)
                                           / CLOCK_PERIOD_NS);
   localparam logic [11:0] SRC_CYC_01 = 12'((SRC_PERIOD_01_NS + CLOCK_PERIOD_NS - 1)
                                           / CLOCK_PERIOD_NS);
   localparam logic [11:0] SRC_CYC_10 = 12'((SRC_PERIOD_10_NS + CLOCK_PERIOD_NS - 1)
                                           / CLOCK_PERIOD_NS);
   // Timer 0 prescale ratios in oscillator periods
   localparam logic [11:0] T0_CYC_UNIT = 12'(OSC_CYCLES);
   // Edge select codes
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Reset values
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [9:0] PWM_RESET = 10'h000;
   localparam logic [11:0] PRESCALE_RESET = 12'h000;
endpackage : tccp_pkg

// ---- testbench/pin_partner.sv ----
`timescale 1ns/100ps
module pin_partner (
   input wire logic clock_i,
   input wire logic pulse_pin_i,
   input wire logic level_i,
   output logic cap_pin0_o,
   output logic cap_pin1_o,
   output int gap_o,
   output int edges_o,
   output int active_o
);
   int now;
   int last;
   logic prev;
   initial begin
      cap_pin0_o = 1'b1;
      cap_pin1_o = 1'b1;
      {now, last, gap_o, edges_o, active_o} = '0;
      prev = 1'b0;
   end
   // Pulled-up interrupt pins, moved off the sampling edge
   task automatic set_pin(input int ch, input logic lvl);
      @(negedge clock_i);
      if (ch == 0)
         cap_pin0_o = lvl;
      else
         cap_pin1_o = lvl;
   endtask : set_pin
   task automatic clear_active();
      @(negedge clock_i);
      active_o = 0;
   endtask : clear_active
   // Measures the pulse pin: spacing of edges and time at active level
   always @(posedge clock_i) begin
      now = now + 1;
      if (pulse_pin_i === level_i)
         active_o = active_o + 1;
      if (pulse_pin_i !== prev) begin
         gap_o = now - last;
         last = now;
         edges_o = edges_o + 1;
      end
      prev = pulse_pin_i;
   end
endmodule : pin_partner

// ---- testbench/timer_capture_compare_pwm_test.sv ----
`timescale 1ns/100ps
module timer_capture_compare_pwm_test;
   import tccp_pkg::*;
   logic clock_i, rstn_i, enable_i, cascade_select_i, timer0_capture_enable_i;
   logic timer1_capture_enable_i, pwm_enable_bit_i, pwm_polarity_i;
   logic pwm_output_pin_select_i, timer0_compare_select_i, capture_input0_i, capture_input1_i;
   logic [2:0] timer0_clock_select_i;
   logic [1:0] timer1_clock_select_i, edge_select0_i, edge_select1_i;
   logic [7:0] compare_data0_i, compare_data1_i, pwm_period_low_i, pwm_duty_low_i;
   logic [3:0] pwm_high_bits_reg_i;
   logic [7:0] read_value0_o, read_value1_o;
   logic timer0_irq_o, timer1_irq_o, ext_irq0_o, ext_irq1_o;
   logic timer0_compare_pin_o, timer1_compare_pin_o;
   int gap, edges, active, ext_n0, tmr_n1, d, k, per, dut, n;
   int fail_count = 0;
   int n_compared = 0;
   int src[3] = '{int'(SRC_CYC_00), int'(SRC_CYC_01), int'(SRC_CYC_10)};
   timer_capture_compare_pwm timer_capture_compare_pwm_inst (.*);
   pin_partner pin_partner_inst (.clock_i(clock_i), .pulse_pin_i(timer1_compare_pin_o),
      .level_i(pwm_polarity_i), .cap_pin0_o(capture_input0_i),
      .cap_pin1_o(capture_input1_i), .gap_o(gap), .edges_o(edges), .active_o(active));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (ext_irq0_o === 1'b1)
         ext_n0 = ext_n0 + 1;
      if (timer1_irq_o === 1'b1)
         tmr_n1 = tmr_n1 + 1;
   end
   task automatic wait_n(input int c);
      repeat (c) @(negedge clock_i);
   endtask : wait_n
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      #900000;
      fail_count++;
      close_out();
   end
   initial begin
      {rstn_i, cascade_select_i, timer0_capture_enable_i, timer1_capture_enable_i} = '0;
      {pwm_enable_bit_i, pwm_polarity_i, pwm_output_pin_select_i, timer0_compare_select_i} = '0;
      {timer0_clock_select_i, timer1_clock_select_i, edge_select0_i, edge_select1_i} = '0;
      {compare_data0_i, pwm_period_low_i, pwm_duty_low_i, pwm_high_bits_reg_i} = '0;
      compare_data1_i = 8'hff;
      enable_i = 1'b1;
      void'($urandom(32'hb06a22df));
      wait_n(10);
      rstn_i = 1'b1;
      // Edge modes: none, falling, rising, both
      timer0_capture_enable_i = 1'b1;
      for (int es = 0; es < 4; es++) begin
         edge_select0_i = 2'(es);
         wait_n(4);
         ext_n0 = 0;
         pin_partner_inst.set_pin(0, 1'b0);
         wait_n(4);
         pin_partner_inst.set_pin(0, 1'b1);
         wait_n(4);
         check("edge irq count", (es == 3) ? 2 : ((es == 0) ? 0 : 1), ext_n0);
      end
      $display("test edge_modes done");
      // Capture of a known elapsed count on timer 1
      timer1_capture_enable_i = 1'b1;
      edge_select1_i = EDGE_FALL;
      k = 3 + $urandom_range(30);
      pin_partner_inst.set_pin(1, 1'b0);
      wait_n(2);
      pin_partner_inst.set_pin(1, 1'b1);
      wait_n(k * src[0] - 3);
      pin_partner_inst.set_pin(1, 1'b0);
      wait_n(3);
      check("captured count", 1, read_value1_o >= 8'(k - 1) && read_value1_o <= 8'(k + 1));
      d = 2 + $urandom_range(3);
      compare_data1_i = 8'(d);
      pin_partner_inst.set_pin(1, 1'b1);
      pin_partner_inst.set_pin(1, 1'b0);
      wait_n(10);
      tmr_n1 = 0;
      wait_n(3 * (d + 1) * src[0]);
      check("capture mode matches", 3, tmr_n1);
      $display("test capture done");
      // Compare output toggling for the three divider clock codes
      timer1_capture_enable_i = 1'b0;
      pwm_output_pin_select_i = 1'b1;
      for (int i = 0; i < 3; i++) begin
         timer1_clock_select_i = 2'(i);
         d = 6 + 4 * i + $urandom_range(3);
         compare_data1_i = 8'(d);
         wait_n(3 * (d + 1) * src[i]);
         check("toggle spacing", (d + 1) * src[i], gap);
      end
      pwm_output_pin_select_i = 1'b0;
      wait_n(5);
      n = edges;
      wait_n(3 * (d + 1) * src[2]);
      check("gated pin edges", n, edges);
      $display("test compare done");
      // PWM after a mid-run reset
      rstn_i = 1'b0;
      wait_n(2);
      rstn_i = 1'b1;
      pwm_enable_bit_i = 1'b1;
      pwm_output_pin_select_i = 1'b1;
      timer1_clock_select_i = TIMER1_CLOCK_SELECT_DIV1;
      for (int i = 0; i < 5; i++) begin
         per = 4 + 3 * i + $urandom_range(2);
         dut = (i == 0) ? 0 : ((i == 1) ? per : $urandom_range(per - 1));
         if (i == 4)
            per = per + 256;
         pwm_polarity_i = 1'($urandom);
         pwm_period_low_i = 8'(per);
         pwm_duty_low_i = 8'(dut);
         pwm_high_bits_reg_i = {2'(per >> 8), 2'(dut >> 8)};
         wait_n(3 * per * src[0]);
         pin_partner_inst.clear_active();
         wait_n(per * src[0]);
         check("pwm active cycles", (dut >= per) ? per * src[0] : dut * src[0], active);
      end
      $display("test pwm done");
      // 16-bit capture across the byte boundary
      pwm_enable_bit_i = 1'b0;
      cascade_select_i = 1'b1;
      timer1_clock_select_i = TIMER1_CLOCK_SELECT_CASCADE;
      {compare_data1_i, compare_data0_i} = 16'hffff;
      edge_select0_i = EDGE_FALL;
      k = 250 + $urandom_range(10);
      pin_partner_inst.set_pin(0, 1'b0);
      wait_n(2);
      pin_partner_inst.set_pin(0, 1'b1);
      wait_n(k * 2 * OSC_CYCLES - 3);
      pin_partner_inst.set_pin(0, 1'b0);
      wait_n(3);
      n = {read_value1_o, read_value0_o};
      check("wide capture", 1, n >= k - 1 && n <= k + 1);
      $display("test wide capture done");
      close_out();
   end
endmodule : timer_capture_compare_pwm_test
